// ### pkg/pfr_regs.vh
// constants for the fractional-frame retrigger waveform generator
`ifndef PFR_REGS_VH
`define PFR_REGS_VH
`define PFR_FRAME_LEN      5'h10
`define PFR_FRAC_HI        15
`define PFR_FRAC_LO        12
`define PFR_RAMP_ONE       2'h0
`define PFR_RAMP_TWO       2'h1
`define PFR_RAMP_FOUR      2'h2
`define PFR_RAMP_CENTER    2'h3
`define PFR_MODE_OFF       4'h0
`define PFR_MODE_STOP      4'h1
`define PFR_MODE_BURST_OPP 4'h3
`define PFR_MODE_BURST_OFF 4'h4
`define PFR_MODE_RETRIG    4'h8
`define PFR_SRC_PIN        1'b1
`endif

// ### rtl/pfr_input_unit.v
// input handling unit: source select, sync, sense control, mode decode
`timescale 1ns/1ps
module pfr_input_unit (
    // clock and reset
    input  wire       mclk,
    input  wire       rst,
    // sources
    input  wire       comp_in,
    input  wire       pin_in,
    // control
    input  wire       src_sel,
    input  wire       sense_high,
    input  wire [3:0] input_mode_field,
    input  wire       honour,
    // results
    output reg        retrig,
    output reg        stop_lvl,
    output reg        burst_opp,
    output reg        burst_off
);
`include "pfr_regs.vh"

    reg  [2:0] warm;
    reg        pin_s1;
    reg        pin_s2;
    reg        cmp_s1;
    reg        cmp_s2;
    reg        prev;
    // both sources pass two flops before the select
    wire       raw    = (src_sel == `PFR_SRC_PIN) ? pin_s2 : cmp_s2;
    wire       active = sense_high ? raw : ~raw;
    // no edge until prev holds a real sample: low-active idle after reset
    wire       edge_a = active & ~prev & warm[2];

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            warm      <= 3'h0;
            pin_s1    <= 1'b0;
            pin_s2    <= 1'b0;
            cmp_s1    <= 1'b0;
            cmp_s2    <= 1'b0;
            prev      <= 1'b0;
            retrig    <= 1'b0;
            stop_lvl  <= 1'b0;
            burst_opp <= 1'b0;
            burst_off <= 1'b0;
        end else begin
            warm      <= {warm[1:0], 1'b1};
            pin_s1    <= pin_in;
            pin_s2    <= pin_s1;
            cmp_s1    <= comp_in;
            cmp_s2    <= cmp_s1;
            prev      <= active;
            retrig    <= honour & edge_a & (input_mode_field == `PFR_MODE_RETRIG);
            stop_lvl  <= honour & active & (input_mode_field == `PFR_MODE_STOP);
            burst_opp <= active & (input_mode_field == `PFR_MODE_BURST_OPP);
            burst_off <= active & (input_mode_field == `PFR_MODE_BURST_OFF);
        end
    end
endmodule

// ### rtl/pfr_generator.v
// fractional-frame waveform generator with input retrigger handling
`timescale 1ns/1ps
module pfr_generator #(
    parameter TW = 12
) (
    // clock and reset
    input  wire          mclk,
    input  wire          rst,
    // timing values and controls from software
    input  wire [TW-1:0] on_time_a,
    input  wire [TW-1:0] on_time_b,
    input  wire [TW-1:0] dead_time_a,
    input  wire [TW-1:0] dead_time_b,
    input  wire [15:0]   part_b_compare,
    input  wire          enhanced_en,
    input  wire [1:0]    ramp_mode,
    input  wire          run,
    input  wire          update_req,
    // input control a
    input  wire [3:0]    input_a_mode,
    input  wire          input_a_src_pin,
    input  wire          input_a_sense_high,
    // input control b
    input  wire [3:0]    input_b_mode,
    input  wire          input_b_src_pin,
    input  wire          input_b_sense_high,
    // sources
    input  wire          comp_a,
    input  wire          comp_b,
    input  wire          external_trigger_pin,
    // outputs
    output reg           stage_output_a,
    output reg           stage_output_b,
    output reg  [3:0]    frame_pos,
    output reg           cycle_end
);
`include "pfr_regs.vh"

    localparam ST_DTA = 2'd0;
    localparam ST_OTA = 2'd1;
    localparam ST_DTB = 2'd2;
    localparam ST_OTB = 2'd3;
    localparam [TW-1:0] TIME_ZERO = {TW{1'b0}};

    reg  [1:0]    state;
    reg  [TW:0]   cnt;
    reg  [TW-1:0] ota;
    reg  [TW-1:0] otb;
    reg  [TW-1:0] dta;
    reg  [TW-1:0] dtb;
    reg  [3:0]    frac;
    reg           enh;
    reg           pend;
    reg           lengthen;
    wire          in_a = (state == ST_DTA) | (state == ST_OTA);
    wire          one_ramp = (ramp_mode == `PFR_RAMP_ONE);
    wire          center = (ramp_mode == `PFR_RAMP_CENTER);
    wire          ra, sa, boa, bfa, rb, sb, bob, bfb;

    ////////////////////////////////////////////////////////////////
    // input units, one per part
    pfr_input_unit u_in_a (
        .mclk             (mclk),
        .rst              (rst),
        .comp_in          (comp_a),
        .pin_in           (external_trigger_pin),
        .src_sel          (input_a_src_pin),
        .sense_high       (input_a_sense_high),
        .input_mode_field (input_a_mode),
        .honour           (one_ramp | in_a),
        .retrig           (ra),
        .stop_lvl         (sa),
        .burst_opp        (boa),
        .burst_off        (bfa)
    );
    pfr_input_unit u_in_b (
        .mclk             (mclk),
        .rst              (rst),
        .comp_in          (comp_b),
        .pin_in           (external_trigger_pin),
        .src_sel          (input_b_src_pin),
        .sense_high       (input_b_sense_high),
        .input_mode_field (input_b_mode),
        .honour           (one_ramp | ~in_a),
        .retrig           (rb),
        .stop_lvl         (sb),
        .burst_opp        (bob),
        .burst_off        (bfb)
    );

    ////////////////////////////////////////////////////////////////
    // frame pattern: lengthen cycle p when rank(bitrev(p)) < d
    wire [3:0] rev;
    genvar     gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_rev
            assign rev[gi] = frame_pos[3 - gi];
        end
    endgenerate
    always @* begin
        lengthen = enh & (rev < frac);
    end

    wire [TW:0] len_dta = {1'b0, dta} + {{TW{1'b0}}, lengthen};
    reg  [TW:0] limit;
    always @* begin
        case (state)
            ST_DTA:  limit = len_dta;
            ST_OTA:  limit = {1'b0, ota};
            ST_DTB:  limit = {1'b0, dtb};
            ST_OTB:  limit = {1'b0, otb};
            default: limit = {1'b0, ota};
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // sub-cycle end and retrigger actions
    wire done = (cnt + 1'b1 >= limit);
    wire retrig_ok = ~center;
    wire jump_b = retrig_ok & ~one_ramp & ra & in_a;
    wire jump_a = retrig_ok & ~one_ramp & rb & ~in_a;
    wire clr = retrig_ok & one_ramp & (ra | rb);
    wire last = (state == ST_OTB) & done;
    // a cycle end that the sequencer really takes
    wire wrap = run & ~clr & ~jump_b & (jump_a | last);
    // zero on-time keeps an output low
    wire on_a_ok = (ota != TIME_ZERO);
    wire on_b_ok = (otb != TIME_ZERO);
    wire kill_a = jump_b | clr | sa | boa | bfa | bfb;
    wire kill_b = jump_a | clr | sb | bob | bfb | bfa;
    wire [3:0] next_frame_pos = frame_pos + 4'h1;

    ////////////////////////////////////////////////////////////////
    // staged timing set, taken only where a cycle ends
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ota  <= TIME_ZERO;
            otb  <= TIME_ZERO;
            dta  <= TIME_ZERO;
            dtb  <= TIME_ZERO;
            frac <= 4'h0;
            enh  <= 1'b0;
            pend <= 1'b0;
        end else if (wrap) begin
            if (pend | update_req) begin
                ota  <= on_time_a;
                otb  <= on_time_b;
                dta  <= dead_time_a;
                dtb  <= dead_time_b;
                frac <= part_b_compare[`PFR_FRAC_HI:`PFR_FRAC_LO];
                enh  <= enhanced_en;
            end
            pend <= 1'b0;
        end else if (update_req) begin
            pend <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // sequencer
    // order: dead a, on a, dead b, on b
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state     <= ST_DTA;
            cnt       <= {(TW+1){1'b0}};
            frame_pos <= 4'h0;
            cycle_end <= 1'b0;
        end else begin
            cycle_end <= 1'b0;
            if (!run) begin
                state <= ST_DTA;
                cnt   <= {(TW+1){1'b0}};
            end else if (clr) begin
                state <= ST_DTA;
                cnt   <= {(TW+1){1'b0}};
            end else if (jump_b) begin
                state <= ST_DTB;
                cnt   <= {(TW+1){1'b0}};
            end else if (jump_a | last) begin
                state     <= ST_DTA;
                cnt       <= {(TW+1){1'b0}};
                cycle_end <= 1'b1;
                frame_pos <= next_frame_pos;
            end else if (done) begin
                state <= state + 2'd1;
                cnt   <= {(TW+1){1'b0}};
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage_output_a <= 1'b0;
            stage_output_b <= 1'b0;
        end else begin
            stage_output_a <= run & (state == ST_OTA) & on_a_ok & ~kill_a;
            stage_output_b <= run & (state == ST_OTB) & on_b_ok & ~kill_b;
        end
    end
endmodule

// ### test/pfr_gen_asserts.sv
// port assertions for the fractional-frame generator
`timescale 1ns/1ps
`include "pfr_regs.vh"
module pfr_gen_asserts (
    // clock and reset
    input wire       mclk,
    input wire       rst,
    // control and inputs
    input wire       run,
    input wire [1:0] ramp_mode,
    input wire [3:0] input_a_mode,
    input wire [3:0] input_b_mode,
    input wire       external_trigger_pin,
    // outputs
    input wire       stage_output_a,
    input wire       stage_output_b,
    input wire [3:0] frame_pos,
    input wire       cycle_end
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_edge_two;
        $rose(external_trigger_pin) && ramp_mode == `PFR_RAMP_TWO;
    endsequence
    a_end_spacing: assert property (cycle_end |=> !cycle_end [*2])
        else $error("cycle end too close");
    a_frame_step: assert property ($changed(frame_pos) |-> frame_pos == $past(frame_pos) + 4'h1)
        else $error("frame step wrong");
    a_frame_cause: assert property ($changed(frame_pos) |-> cycle_end || $past(cycle_end))
        else $error("frame moved mid cycle");
    a_reset_clear: assert property ($past(rst) |-> frame_pos == 4'h0 && !cycle_end)
        else $error("frame not cleared");
    a_idle_low: assert property (!run ##1 !run |-> !stage_output_a && !stage_output_b)
        else $error("outputs on while idle");
    a_idle_no_end: assert property (!run ##1 !run |-> !cycle_end)
        else $error("cycle end while idle");
    a_cut_a: assert property (s_edge_two ##0 (input_a_mode == `PFR_MODE_RETRIG && stage_output_a)
        |-> ##[1:8] !stage_output_a) else $error("output a not cut");
    a_cut_b: assert property (s_edge_two ##0 (input_b_mode == `PFR_MODE_RETRIG && stage_output_b)
        |-> ##[1:8] !stage_output_b) else $error("output b not cut");
endmodule
bind pfr_generator pfr_gen_asserts u_chk (.mclk(mclk), .rst(rst), .run(run),
    .ramp_mode(ramp_mode), .input_a_mode(input_a_mode), .input_b_mode(input_b_mode),
    .external_trigger_pin(external_trigger_pin), .stage_output_a(stage_output_a),
    .stage_output_b(stage_output_b), .frame_pos(frame_pos), .cycle_end(cycle_end));

// ### test/pfr_far_model.sv
// far-side model: comparator outputs and external trigger pin
`timescale 1ns/1ps
module pfr_far_model (
    // clock
    input  wire mclk,
    // lines toward the stage
    output reg  comp_a = 1'b0,
    output reg  comp_b = 1'b0,
    output reg  external_trigger_pin = 1'b0
);
    // lines change just after an edge and hold until the next call
    task set_line(input cmp, input v);
        @(posedge mclk);
        #1;
        if (cmp) comp_a = v;
        if (cmp) comp_b = v;
        if (!cmp) external_trigger_pin = v;
    endtask
endmodule

// ### test/pwm_fractional_frame_retrigger_tb.sv
// self-checking bench for the fractional-frame generator
`timescale 1ns/1ps
`include "pfr_regs.vh"
module pwm_fractional_frame_retrigger_tb;
    reg         mclk = 1'b0, rst = 1'b1, enh = 1'b0, run = 1'b0, upd = 1'b0;
    reg         src = 1'b1, sen = 1'b1;
    reg  [11:0] ota = 12'h000, otb = 12'h000, dta = 12'h000, dtb = 12'h002;
    reg  [15:0] cmpb = 16'h0000;
    reg  [3:0]  am = 4'h0, bm = 4'h0;
    reg  [1:0]  ramp = 2'h0;
    wire        ca, cb, pin, oa, ob, ce;
    wire [3:0]  fp;
    integer     n_mismatch = 0, checks_done = 0, p, k, c;
    always #2.5 mclk = ~mclk;
    pfr_far_model u_far (.mclk(mclk), .comp_a(ca), .comp_b(cb), .external_trigger_pin(pin));
    pfr_generator u_dut (
        .mclk(mclk), .rst(rst), .on_time_a(ota), .on_time_b(otb), .dead_time_a(dta),
        .dead_time_b(dtb), .part_b_compare(cmpb), .enhanced_en(enh), .ramp_mode(ramp),
        .run(run), .update_req(upd), .input_a_mode(am), .input_a_src_pin(src),
        .input_a_sense_high(sen), .input_b_mode(bm), .input_b_src_pin(src),
        .input_b_sense_high(sen), .comp_a(ca), .comp_b(cb), .external_trigger_pin(pin),
        .stage_output_a(oa), .stage_output_b(ob), .frame_pos(fp), .cycle_end(ce)
    );
    task tick(input integer n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task chk(input string what, input [31:0] exp, input [31:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task next_end(output integer q);
        q = 0;
        do begin
            tick(1);
            q = q + 1;
        end while (ce !== 1'b1 && q < 300);
    endtask
    // new set applies at the next end; skip one whole new cycle too
    task load(input [11:0] a, input [11:0] t, input [3:0] d);
        dta = a;
        ota = t;
        otb = t;
        cmpb = {d, 12'h000};
        upd = 1'b1;
        tick(1);
        upd = 1'b0;
        next_end(p);
        next_end(p);
    endtask
    task t_period;
        load(12'h003, 12'h005, 4'h0);
        next_end(p);
        chk("period", 15, p);
        c = 0;
        k = 0;
        repeat (15) begin
            tick(1);
            c = c + (oa === 1'b1);
            k = k + (ob === 1'b1);
        end
        chk("on time a", 5, c);
        chk("on time b", 5, k);
        dta = 12'h009;
        next_end(p);
        chk("unstaged period", 15, p);
        load(12'h009, 12'h005, 4'h0);
        next_end(p);
        chk("new period", 21, p);
    endtask
    task t_frac;
        enh = 1'b1;
        for (k = 0; k < 16; k = k + 1) begin
            load(12'h003, 12'h005, k[3:0]);
            repeat (16) next_end(p);
            c = 0;
            repeat (16) begin
                next_end(p);
                c = c + (p == 16);
            end
            chk("lengthened", k, c);
        end
        enh = 1'b0;
    endtask
    task trig(input [1:0] rm, input [3:0] ma, mb, input s, cm, wb, cut);
        ramp = rm;
        sen = s;
        src = ~cm;
        u_far.set_line(cm, ~s);
        tick(40);
        am = ma;
        bm = mb;
        for (k = 0; k < 300 && (wb ? ob : oa) !== 1'b0; k = k + 1) tick(1);
        for (k = 0; k < 300 && (wb ? ob : oa) !== 1'b1; k = k + 1) tick(1);
        chk("on", 1, wb ? ob : oa);
        u_far.set_line(cm, s);
        c = 0;
        repeat (8) begin
            tick(1);
            c = c | ((wb ? ob : oa) === 1'b0);
        end
        chk("cut", cut, c);
        u_far.set_line(cm, ~s);
        am = 4'h0;
        bm = 4'h0;
        tick(60);
    endtask
    task t_trig;
        load(12'h00a, 12'h01e, 4'h0);
        trig(`PFR_RAMP_TWO, 4'h8, 4'h0, 1, 0, 0, 1);
        trig(`PFR_RAMP_TWO, 4'h0, 4'h8, 1, 0, 1, 1);
        trig(`PFR_RAMP_TWO, 4'h0, 4'h8, 1, 0, 0, 0);
        trig(`PFR_RAMP_FOUR, 4'h8, 4'h0, 1, 0, 0, 1);
        trig(`PFR_RAMP_CENTER, 4'h8, 4'h8, 1, 0, 1, 0);
        trig(`PFR_RAMP_ONE, 4'h8, 4'h0, 1, 0, 1, 1);
        trig(`PFR_RAMP_ONE, 4'h0, 4'h0, 1, 0, 1, 0);
        trig(`PFR_RAMP_ONE, 4'h8, 4'h0, 0, 0, 1, 1);
        trig(`PFR_RAMP_ONE, 4'h8, 4'h0, 1, 1, 1, 1);
        trig(`PFR_RAMP_TWO, 4'h4, 4'h0, 1, 0, 0, 1);
        trig(`PFR_RAMP_TWO, 4'h3, 4'h0, 1, 0, 0, 1);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        summarize;
    end
    initial begin
        tick(10);
        rst = 1'b0;
        tick(4);
        chk("frame_pos", 0, fp);
        chk("outputs", 0, {oa, ob, ce});
        run = 1'b1;
        t_period;
        t_frac;
        t_trig;
        summarize;
    end
endmodule
